// ---- hw/loop_lock_detect.sv ----
`timescale 1ns/100ps
// ==============================================
// phase and frequency match detector
// ==============================================
module loop_lock_detect #(
    parameter int PERIOD = 16,
    parameter int GOOD_N = 8
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic enable,     // loop powered
    input  wire logic restart,    // configuration changed
    input  wire logic ref_edge,   // reference rising edge pulse
    input  wire logic fb_edge,    // feedback rising edge pulse
    output logic      locked
);
    logic [7:0] per_ff, nxt_per;       // ticks since reference edge
    logic [7:0] ph_ff, nxt_ph;         // ticks since feedback edge
    logic [7:0] last_ph_ff, nxt_last;  // phase at previous compare
    logic [3:0] good_ff, nxt_good;     // consecutive matches
    logic       good;

    // ==============================================
    // compare at every reference edge
    // ==============================================
    always_comb begin
        good     = (per_ff == 8'(PERIOD - 1)) && (ph_ff == last_ph_ff);
        nxt_per  = (ref_edge || per_ff == 8'hff) ? 8'h00 : per_ff + 8'h01;
        nxt_ph   = (fb_edge || ph_ff == 8'hff) ? 8'h00 : ph_ff + 8'h01;
        nxt_last = ref_edge ? ph_ff : last_ph_ff;
        nxt_good = good_ff;
        if (!enable || restart) begin
            nxt_good = 4'h0;                     // off loop never locked
        end else if (ref_edge) begin
            if (!good)
                nxt_good = 4'h0;                 // any slip drops lock
            else if (good_ff != 4'(GOOD_N))
                nxt_good = good_ff + 4'h1;
        end else if (per_ff == 8'(2 * PERIOD)) begin
            nxt_good = 4'h0;                     // reference went missing
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            per_ff     <= 8'h00;
            ph_ff      <= 8'h00;
            last_ph_ff <= 8'h00;
            good_ff    <= 4'h0;
        end else if (clk_en) begin
            per_ff     <= nxt_per;
            ph_ff      <= nxt_ph;
            last_ph_ff <= nxt_last;
            good_ff    <= nxt_good;
        end
    end

    assign locked = (good_ff == 4'(GOOD_N));

    // a bad compare clears lock on the next edge
    slip_unlock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && ref_edge && !good) |=> !locked)
        else $error("lock held after a phase or period slip");
endmodule

// ---- hw/mux16_serializer_clocking.sv ----
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module mux16_serializer_clocking (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [15:0] par_in_lane,
    input  wire logic        system_ref_in,
    input  wire logic        fwd_ref_in,
    output logic             serial_out,
    output logic             fast_clk_out,
    output logic             fast_drv_en,
    output logic             slow_clk_out,
    output logic             cleaned_ref_out,
    output logic             main_loop_locked,
    output logic             aux_loop_locked,
    output logic             vco_11g0_pwr,
    output logic             vco_11g8_pwr,
    output logic             aux_loop_pwr,
    output logic             term_diff_100
);
    // ==============================================
    // decode of the clocking arrangement
    // ==============================================
    // used by the loop steering and by the status read
    function automatic mux_pkg::mode_type decode_mode(input mux_pkg::ctrl_type c);
        if (c.aux_dis)
            decode_mode = mux_pkg::MODE_DEFAULT;
        else if (c.counter_clk)
            decode_mode = mux_pkg::MODE_COUNTER;
        else
            decode_mode = mux_pkg::MODE_FORWARD;
    endfunction

    // ==============================================
    // declarations
    // ==============================================
    localparam int SW = mux_pkg::SYNC_W;

    mux_pkg::ctrl_type ctrl_ff, nxt_ctrl;     // software control bits
    mux_pkg::stat_type stat;                  // live status view
    mux_pkg::mode_type mode;                  // decoded arrangement
    logic              ack_ff, nxt_ack;       // bus answer cycle
    logic [31:0]       rdata_ff, nxt_rdata;   // read data holding
    logic              restart_ff, nxt_restart; // config just changed
    logic              bus_req;               // read or write pending
    logic              ctrl_hit;              // write accepted to control

    logic [SW-1:0]     s1_ff, s2_ff, s3_ff;   // pin synchronisers
    logic [SW-1:0]     filt_ff, nxt_filt;     // agreed pin levels
    logic [1:0]        rprev_ff, nxt_rprev;   // previous reference levels
    logic              sys_edge, fwd_edge;    // reference rising edges

    logic [mux_pkg::DIV_STAGES-1:0] div_ff, nxt_div; // divider chain
    logic              c16_rise, c16_fall;    // word clock edges
    logic [3:0]        aux_ff, nxt_aux;       // aux oscillator phase
    logic              aux_snap;              // aux reference edge
    logic              aux_edge;              // aux output rising edge
    logic              main_ref_edge;         // selected main reference

    logic              slow_ff, nxt_slow;     // low-speed clock out
    logic              clean_ff, nxt_clean;   // aux clock out
    logic              fast_ff, nxt_fast;     // full-rate clock out

    // ==============================================
    // register bus slave
    // ==============================================
    // every access waits exactly one cycle, then completes
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_ff;
    assign ctrl_hit        = avs_write & ack_ff & (avs_address == mux_pkg::CTRL_OFS);
    assign mode            = decode_mode(ctrl_ff);
    assign stat            = '{mode: mode, aux_locked: aux_loop_locked,
                               main_locked: main_loop_locked};

    // bus next state
    always_comb begin
        nxt_ack     = bus_req & ~ack_ff;
        nxt_rdata   = rdata_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_restart = 1'b0;
        if (avs_read && !ack_ff) begin
            case (avs_address)
                mux_pkg::CTRL_OFS: nxt_rdata = {25'h0, ctrl_ff};
                mux_pkg::STAT_OFS: nxt_rdata = {27'h0, stat};
                default:           nxt_rdata = 32'h0; // unmapped reads zero
            endcase
        end
        if (ctrl_hit) begin
            nxt_ctrl = mux_pkg::ctrl_type'(avs_writedata[mux_pkg::CTRL_W-1:0]);
            // a changed setting restarts lock so users must wait again
            nxt_restart = (nxt_ctrl != ctrl_ff);
        end
    end

    // bus registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff     <= 1'b0;
            rdata_ff   <= 32'h0;
            ctrl_ff    <= mux_pkg::CTRL_RST;
            restart_ff <= 1'b0;
        end else if (clk_en) begin
            ack_ff     <= nxt_ack;
            rdata_ff   <= nxt_rdata;
            ctrl_ff    <= nxt_ctrl;
            restart_ff <= nxt_restart;
        end
    end

    assign avs_readdata = rdata_ff;

    // ==============================================
    // pin synchronisers
    // ==============================================
    // a level counts once stages two and three agree, so a single
    // metastable sample never reaches the serializer
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_comb begin
                nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : filt_ff[gi];
            end
        end
    endgenerate

    // synchroniser chain
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff   <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            filt_ff <= '0;
        end else if (clk_en) begin
            s1_ff   <= {fwd_ref_in, system_ref_in, par_in_lane};
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    // reference edge detection on agreed levels
    always_comb begin
        nxt_rprev = filt_ff[SW-1:SW-2];
        sys_edge  = filt_ff[SW-2] & ~rprev_ff[0];
        fwd_edge  = filt_ff[SW-1] & ~rprev_ff[1];
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            rprev_ff <= 2'b00;
        else if (clk_en)
            rprev_ff <= nxt_rprev;
    end

    // ==============================================
    // divider chain
    // ==============================================
    // each stage toggles when every stage below is high, the
    // synchronous form of a ripple of divide-by-two cells
    generate
        for (gi = 0; gi < mux_pkg::DIV_STAGES; gi++) begin : g_div
            if (gi == 0) begin : g_first
                always_comb begin
                    nxt_div[gi] = ~div_ff[gi];
                end
            end else begin : g_next
                always_comb begin
                    nxt_div[gi] = div_ff[gi] ^ (&div_ff[gi-1:0]);
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            div_ff <= '0;
        else if (clk_en)
            div_ff <= nxt_div;
    end

    // word clock edges, one tick ahead of the stage change
    assign c16_rise = ~div_ff[mux_pkg::C16_STAGE] & (&div_ff[mux_pkg::C16_STAGE-1:0]);
    assign c16_fall = &div_ff[mux_pkg::C16_STAGE:0];

    // ==============================================
    // secondary loop oscillator
    // ==============================================
    // the aux phase snaps to its reference edge and free-runs
    // between, so a jittery forwarded clock comes out clean
    always_comb begin
        case (mode)
            mux_pkg::MODE_FORWARD: aux_snap = fwd_edge;
            mux_pkg::MODE_COUNTER: aux_snap = c16_rise;
            mux_pkg::MODE_DEFAULT: aux_snap = 1'b0;
            default:               aux_snap = 1'b0;
        endcase
        if (mode == mux_pkg::MODE_DEFAULT)
            nxt_aux = 4'h0;                  // powered off
        else if (aux_snap)
            nxt_aux = 4'h0;
        else
            nxt_aux = aux_ff + 4'h1;
        aux_edge = (mode != mux_pkg::MODE_DEFAULT) && (aux_ff == 4'h7);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            aux_ff <= 4'h0;
        else if (clk_en)
            aux_ff <= nxt_aux;
    end

    // ==============================================
    // lock detectors
    // ==============================================
    // forward mode feeds the cleaned clock to the main loop
    assign main_ref_edge = (mode == mux_pkg::MODE_FORWARD) ? aux_edge : sys_edge;

    // main loop: reference against the word clock
    loop_lock_detect #(
        .PERIOD (mux_pkg::FB_PERIOD),
        .GOOD_N (mux_pkg::LOCK_GOOD)
    ) u_main_lock (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .enable   (1'b1),
        .restart  (restart_ff),
        .ref_edge (main_ref_edge),
        .fb_edge  (c16_rise),
        .locked   (main_loop_locked)
    );

    // aux loop: its own phase against its reference
    loop_lock_detect #(
        .PERIOD (mux_pkg::FB_PERIOD),
        .GOOD_N (mux_pkg::LOCK_GOOD)
    ) u_aux_lock (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .enable   (mode != mux_pkg::MODE_DEFAULT),
        .restart  (restart_ff),
        .ref_edge (aux_snap),
        .fb_edge  (aux_edge),
        .locked   (aux_loop_locked)
    );

    // ==============================================
    // serializer
    // ==============================================
    word_serializer #(
        .W (mux_pkg::WORD_W)
    ) u_ser (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .clk_en       (clk_en),
        .load         (c16_fall),
        .first_lane15 (ctrl_ff.first_lane15),
        .word         (filt_ff[mux_pkg::WORD_W-1:0]),
        .serial_out   (serial_out)
    );

    // ==============================================
    // clock outputs
    // ==============================================
    // full-rate clock toggles per bit; fast_off holds it low and gates the driver,
    // data keeps flowing with it off
    always_comb begin
        nxt_fast  = ctrl_ff.fast_off ? 1'b0 : ~fast_ff;
        nxt_slow  = ctrl_ff.div16_sel ? nxt_div[mux_pkg::C16_STAGE]
                                      : nxt_div[mux_pkg::C64_STAGE];
        nxt_clean = (mode == mux_pkg::MODE_DEFAULT) ? 1'b0 : nxt_aux[3];
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_ff  <= 1'b0;
            slow_ff  <= 1'b0;
            clean_ff <= 1'b0;
        end else if (clk_en) begin
            fast_ff  <= nxt_fast;
            slow_ff  <= nxt_slow;
            clean_ff <= nxt_clean;
        end
    end

    assign fast_clk_out    = fast_ff;
    assign slow_clk_out    = slow_ff;
    assign cleaned_ref_out = clean_ff;

    // ==============================================
    // static power and termination controls
    // ==============================================
    assign fast_drv_en   = ~ctrl_ff.fast_off;
    assign vco_11g0_pwr  = ctrl_ff.band_11g0;
    assign vco_11g8_pwr  = ~ctrl_ff.band_11g0;
    assign aux_loop_pwr  = ~ctrl_ff.aux_dis;
    assign term_diff_100 = ctrl_ff.term_single;

    // ==============================================
    // checks
    // ==============================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    slow_div_a: assert property (
        clk_en |=> slow_clk_out == $past(ctrl_ff.div16_sel ? nxt_div[3] : nxt_div[5]))
        else $error("slow clock output from wrong divider stage");
    word_edge_a: assert property (
        (clk_en && c16_fall) |=> (!clk_en || div_ff[3:0] == 4'h0))
        else $error("word clock fall not at divider wrap");
    band_pwr_a: assert property (
        (vco_11g0_pwr != vco_11g8_pwr) && (vco_11g0_pwr == ctrl_ff.band_11g0))
        else $error("oscillator power select broken");
    fast_drv_a: assert property (
        (clk_en && ctrl_ff.fast_off) |=> (!fast_clk_out && !fast_drv_en))
        else $error("clock driver active while off");
    aux_off_a: assert property (
        (clk_en && mode == mux_pkg::MODE_DEFAULT) ##1 clk_en |=> !aux_loop_locked)
        else $error("aux lock reported while aux loop off");
    fwd_ref_a: assert property (
        (mode == mux_pkg::MODE_FORWARD) |-> (main_ref_edge == aux_edge))
        else $error("forward mode main reference not cleaned clock");
    ctrl_write_a: assert property (
        (clk_en && ctrl_hit && avs_writedata[6:0] != ctrl_ff) |=> ##1
        (!main_loop_locked || !clk_en))
        else $error("lock kept across a configuration change");
    bus_wait_a: assert property (
        (clk_en && bus_req && !ack_ff) |-> avs_waitrequest ##1 (!clk_en || !avs_waitrequest))
        else $error("bus answer not one cycle after request");

    fwd_lock_c: cover property (mode == mux_pkg::MODE_FORWARD && main_loop_locked && aux_loop_locked);
    cnt_lock_c: cover property (mode == mux_pkg::MODE_COUNTER && aux_loop_locked);
    def_lock_c: cover property (mode == mux_pkg::MODE_DEFAULT && main_loop_locked);
endmodule

// ---- hw/mux_pkg.sv ----
// ==============================================
// shared constants and types
// ==============================================
package mux_pkg;
    // lane count and divider shape
    localparam int WORD_W     = 16;       // parallel lanes per word
    localparam int DIV_STAGES = 6;        // four /2 stages plus two for /64
    localparam int C16_STAGE  = 3;        // stage output at full rate / 16
    localparam int C64_STAGE  = 5;        // stage output at full rate / 64
    localparam int FB_PERIOD  = 16;       // feedback period in full-rate ticks
    localparam int LOCK_GOOD  = 8;        // matching compares before lock
    localparam int SYNC_W     = 18;       // lanes plus two reference pins

    // register map, byte addresses
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam int         CTRL_W   = 7;
    localparam int         STAT_W   = 5;
    // aux off, counter clk, 11.8 band, /16 out, driver on, 100 ohm, lane0 first
    localparam logic [6:0] CTRL_RST = 7'h2b;

    // control register layout, bit 0 at the bottom
    typedef struct packed {
        logic first_lane15;   // bit 6: lane 15 leaves first
        logic term_single;    // bit 5: 1 = 100 ohm diff, 0 = 50 ohm single
        logic fast_off;       // bit 4: full-rate clock driver off
        logic div16_sel;      // bit 3: slow output /16 when 1, /64 when 0
        logic band_11g0;      // bit 2: 11.0 GHz oscillator when 1
        logic counter_clk;    // bit 1: 1 = counter, 0 = forward clocking
        logic aux_dis;        // bit 0: secondary loop off
    } ctrl_type;

    // clocking arrangements
    typedef enum logic [2:0] {
        MODE_DEFAULT = 3'b001,
        MODE_FORWARD = 3'b010,
        MODE_COUNTER = 3'b100
    } mode_type;

    // status register layout
    typedef struct packed {
        mode_type mode;        // bits 4:2
        logic     aux_locked;  // bit 1
        logic     main_locked; // bit 0
    } stat_type;
endpackage

// ---- hw/word_serializer.sv ----
`timescale 1ns/100ps
// ==============================================
// 16 to 1 shift serializer
// ==============================================
module word_serializer #(
    parameter int W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    input  wire logic         load,         // word clock falling edge
    input  wire logic         first_lane15, // order select
    input  wire logic [W-1:0] word,         // bit i is lane i
    output logic              serial_out
);
    logic [W-1:0] sh_ff, nxt_sh;   // bits still to leave
    logic         ser_ff, nxt_ser; // registered serial bit
    logic [W-1:0] ordered;         // first bit at the top

    // ==============================================
    // load on word edge, shift one bit a tick
    // ==============================================
    always_comb begin
        for (int i = 0; i < W; i++)
            ordered[i] = first_lane15 ? word[i] : word[W-1-i];
        if (load) begin
            nxt_ser = ordered[W-1];
            nxt_sh  = {ordered[W-2:0], 1'b0};
        end else begin
            nxt_ser = sh_ff[W-1];
            nxt_sh  = {sh_ff[W-2:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_ff  <= '0;
            ser_ff <= 1'b0;
        end else if (clk_en) begin
            sh_ff  <= nxt_sh;
            ser_ff <= nxt_ser;
        end
    end

    assign serial_out = ser_ff;

    first_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && load) |=> serial_out == ($past(first_lane15) ? $past(word[W-1]) : $past(word[0])))
        else $error("wrong lane serialized first");
    second_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (clk_en && load && !first_lane15) ##1 clk_en |=> serial_out == $past(word[1], 2))
        else $error("second serial bit is not lane 1");
endmodule

// ---- tb/tb_mux16_serializer_clocking.sv ----
`timescale 1ns/100ps
// ==============================================
// self-checking bench
// ==============================================
module tb_mux16_serializer_clocking;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, stall = 1'b0, ce = 1'b1, cnt = 1'b0, cr;
    logic [2:0]  hold;
    logic [3:0]  a_q = 4'h0;
    logic        rd_q = 1'b0, wr_q = 1'b0, wq, fc, fe, sc, ml, al, v0, v8, ap, td, so, sr, fr;
    logic [31:0] wd_q = 32'h0, rdat, rd, seed = 32'd41;
    logic [15:0] lanes, word = 16'h0;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    always #10 ref_clk = ~ref_clk;
    mux16_serializer_clocking DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce),
        .avs_address(a_q), .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wd_q),
        .avs_readdata(rdat), .avs_waitrequest(wq), .par_in_lane(lanes), .system_ref_in(sr),
        .fwd_ref_in(fr), .serial_out(so), .fast_clk_out(fc), .fast_drv_en(fe), .slow_clk_out(sc),
        .cleaned_ref_out(cr), .main_loop_locked(ml), .aux_loop_locked(al), .vco_11g0_pwr(v0),
        .vco_11g8_pwr(v8), .aux_loop_pwr(ap), .term_diff_100(td));
    upstream_model up (.ref_clk(ref_clk), .stall(stall), .counter(cnt), .aux_clk(cr), .word(word),
        .par_in_lane(lanes),
        .system_ref_in(sr), .fwd_ref_in(fr));
    // ==============================================
    // helpers
    // ==============================================
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // avalon access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        a_q <= a;
        wd_q <= d;
        wr_q <= w;
        rd_q <= ~w;
        do begin @(posedge ref_clk); n++; end while (wq !== 1'b0 && n < 50);
        if (n >= 50) err_count++;
        rd = rdat;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask
    task automatic wait_lock(input logic aux);
        // a changed setting drops lock two edges after the write lands
        repeat (3) @(posedge ref_clk);
        for (int n = 0; n < 800 && !(ml === 1'b1 && (!aux || al === 1'b1)); n++) @(posedge ref_clk);
    endtask
    // period of the slow clock in bit times
    task automatic chk_slow(input logic aux, input int exp);
        int n, e;
        logic p;
        n = 0;
        e = 0;
        p = aux ? cr : sc;
        while (e < 2 && n < 300) begin
            @(negedge ref_clk);
            if (e == 1) n++;
            if ((aux ? cr : sc) && !p) e++;
            p = aux ? cr : sc;
        end
        cmp(n, exp);
    endtask
    // stream of a held word must be some rotation of the lane order
    task automatic chk_ser(input logic l15);
        logic [31:0] r;
        logic [15:0] s, q;
        int hit;
        r = xs();
        @(posedge ref_clk);
        word <= r[15:0];
        hit = 0;
        repeat (48) @(negedge ref_clk);
        for (int k = 0; k < 16; k++) begin @(negedge ref_clk); q = {q[14:0], so}; end
        for (int k = 0; k < 16; k++) s[k] = l15 ? r[k] : r[15-k];
        for (int k = 0; k < 16; k++) if (((s << k) | (s >> (16 - k))) === q) hit = 1;
        cmp(q, hit ? q : s);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin err_count++; finish_test(); end
    end
    // ==============================================
    // main sequence
    // ==============================================
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, 4'h0, 0); cmp(rd, 32'h2b);
        cmp({td, v8, v0, fe, ap}, 5'b11010);
        // a low clock enable holds the fast clock, slow clock and serial outputs still
        @(posedge ref_clk);
        ce <= 1'b0;
        @(negedge ref_clk);
        hold = {fc, sc, so};
        repeat (5) @(negedge ref_clk);
        cmp({fc, sc, so}, hold);
        @(posedge ref_clk);
        ce <= 1'b1;
        @(negedge ref_clk);
        hold[0] = fc;
        @(negedge ref_clk);
        cmp(fc, !hold[0]);
        bus(1'b1, 4'h8, 32'h7f); bus(1'b0, 4'h8, 0); cmp(rd, 0);
        bus(1'b0, 4'h0, 0); cmp(rd, 32'h2b);
        chk_slow(1'b0, 16);
        chk_ser(1'b0);
        wait_lock(1'b0); bus(1'b0, 4'h4, 0); cmp({rd[4:2], rd[0]}, 4'b0011);
        bus(1'b1, 4'h0, 32'h28); wait_lock(1'b1); bus(1'b0, 4'h4, 0);
        cmp(rd[4:0], 5'b01011);
        bus(1'b1, 4'h0, 32'h2a); cnt <= 1'b1; wait_lock(1'b1); bus(1'b0, 4'h4, 0);
        cmp(rd[4:0], 5'b10011);
        chk_slow(1'b1, 16);
        bus(1'b1, 4'h0, 32'h57); cnt <= 1'b0; repeat (2) @(negedge ref_clk);
        cmp({fc, fe, v0, v8, td}, 5'b00100);
        cmp(cr, 1'b0);
        chk_slow(1'b0, 64);
        chk_ser(1'b1);
        wait_lock(1'b0); stall <= 1'b1; repeat (60) @(negedge ref_clk);
        cmp(ml, 1'b0);
        finish_test();
    end
endmodule

// ---- tb/upstream_model.sv ----
`timescale 1ns/100ps
// ==============================================
// upstream source: lanes and references
// ==============================================
module upstream_model (
    input  wire logic        ref_clk,
    input  wire logic        stall,
    input  wire logic        counter,   // counter clocking selected
    input  wire logic        aux_clk,   // device's low-speed launch clock
    input  wire logic [15:0] word,
    output logic [15:0]      par_in_lane,
    output logic             system_ref_in,
    output logic             fwd_ref_in
);
    logic [3:0] ph_ff = 4'h0; // reference phase count
    // stalling freezes system_ref_in, and fwd_ref_in unless counter is set, so the device sees a missing clock
    always_ff @(posedge ref_clk) begin
        ph_ff <= stall ? ph_ff : ph_ff + 4'h1;
    end
    assign system_ref_in = ph_ff[3];
    // counter clocking: the forwarded clock is launched off the device's own clock
    assign fwd_ref_in    = counter ? aux_clk : ph_ff[3];
    assign par_in_lane   = word;
endmodule
